// ### logic/dsa_pkg.sv
// shared constants and types of the debug sideband and authentication block
package dsa_pkg;
    // avalon register window, byte addresses
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CHAN_RX = 8'h04;
    localparam logic [7:0] OFS_CHAN_TX = 8'h08;
    localparam logic [7:0] OFS_PWR_CTRL = 8'h0C;
    localparam logic [7:0] OFS_PWR_STAT = 8'h10;
    localparam logic [7:0] OFS_AUTH_STAT = 8'h14;
    localparam logic [7:0] OFS_ROM_BASE = 8'h18;
    localparam logic [7:0] OFS_SELF_OFS = 8'h1C;
    localparam logic [7:0] OFS_OS_LOCK = 8'h20;
    localparam logic [7:0] OFS_RESTART = 8'h24;

    // status and control field positions
    localparam int BIT_HALTED = 0;
    localparam int BIT_RESTARTED = 1;
    localparam int ENTRY_LO = 2;
    localparam int ENTRY_HI = 5;
    localparam int BIT_FORCE_ACK = 10;
    localparam int MODE_LO = 14;
    localparam int MODE_HI = 15;
    localparam int BIT_TX_FULL = 29;
    localparam int BIT_RX_FULL = 30;
    localparam int BIT_NO_PWR_DOWN = 0;
    localparam int BIT_PWR_DOWN_REQ = 0;
    localparam int BIT_OS_LOCK = 0;
    localparam int BIT_RESTART_REQ = 1;
    localparam int BIT_CFG_VALID = 0;
    localparam int CFG_LO = 12;
    localparam int CFG_HI = 31;

    // field values
    localparam logic [3:0] ENTRY_EXT_HALT = 4'h4;
    localparam logic [3:0] ENTRY_RESET = 4'h0;
    localparam logic [1:0] MODE_NONE = 2'h0;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    // cycles after reset release before the synchronised os-lock strap is valid
    localparam logic [1:0] LOCK_CAPTURE_CYCLES = 2'h2;

    // debug permissions decoded from the authentication inputs
    typedef struct packed {
        logic secure_invasive;
        logic nonsecure_invasive;
        logic secure_noninvasive;
        logic nonsecure_noninvasive;
    } dsa_perm_t;

    // processor side of the communications channel
    typedef struct packed {
        logic rx_read;
        logic tx_write;
        logic [31:0] tx_data;
    } dsa_core_req_t;

    typedef enum logic [1:0] {
        PWR_ON = 2'b00,
        PWR_WAIT_IDLE = 2'b01,
        PWR_ACKED = 2'b10
    } dsa_pwr_state_t;
endpackage : dsa_pkg

// ### logic/dsa_sync.sv
// two flip-flop level synchroniser for pins entering the core clock domain
`timescale 1ns/1ps
`default_nettype none
module dsa_sync #(
    parameter int WIDTH = 1
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] stage;

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            stage <= '0;
            q <= '0;
        end else begin
            stage <= d;
            q <= stage;
        end
    end
endmodule : dsa_sync
`default_nettype wire

// ### logic/dsa_top.sv
// debug sideband logic: halt handshake, channel flags, power-down, os lock, config and authentication
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - external halt request enters debug state and records entry method 0100
// - acknowledge rises once debug state is entered
// - force-acknowledge bit 10 also drives acknowledge high
// - receive-pending output equals receive-register-full flag, status bit 30
// - transmit-ready output equals inverse of transmit-register-full flag, bit 29
// - no-power-down output follows power control bit 0
// - power status bit 0 reads current power-down request level
// - power-down acknowledge tells system core voltage may drop
// - os lock set after reset release from os-lock-init input, else clear
// - rom base input gives bits 31:12 of debug rom, with valid
// - self offset input gives bits 31:12 of register map offset, with valid
// - invasive permissions decoded from invasive and secure-invasive enables
// - noninvasive permissions decoded from all four enables
// - invasive enable low forces mode field 00 and ignores halts
// - authentication changes are visible to software only through status polling
module dsa_top (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic ext_halt_request,
    output logic debug_state_acknowledge,
    output logic channel_receive_pending,
    output logic channel_transmit_ready,
    input wire dsa_pkg::dsa_core_req_t core_req,
    output logic [31:0] core_rx_data,
    output logic core_halted,
    input wire logic core_quiescent,
    output logic no_power_down_out,
    input wire logic power_down_request_in,
    output logic power_down_ack_out,
    input wire logic os_lock_init_in,
    output logic os_lock,
    input wire logic [19:0] rom_base_cfg,
    input wire logic rom_base_cfg_valid,
    input wire logic [19:0] self_offset_cfg,
    input wire logic self_offset_cfg_valid,
    input wire logic invasive_enable,
    input wire logic noninvasive_enable,
    input wire logic secure_invasive_enable,
    input wire logic secure_noninvasive_enable,
    output dsa_pkg::dsa_perm_t debug_permission
);
    // merge a write word into a register under the byte enables
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_val, input logic [31:0] new_val,
                                                input logic [3:0] be);
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = new_val[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge_bytes

    // synchronised pins
    logic halt_req_s;
    logic pwr_req_s;
    logic lock_init_s;
    logic inv_en_s;
    logic ninv_en_s;
    logic sinv_en_s;
    logic sninv_en_s;
    logic [19:0] rom_base_s;
    logic rom_valid_s;
    logic [19:0] self_ofs_s;
    logic self_valid_s;

    dsa_sync #(.WIDTH(7)) u_sync_ctl (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .d({ext_halt_request, power_down_request_in, os_lock_init_in, invasive_enable,
            noninvasive_enable, secure_invasive_enable, secure_noninvasive_enable}),
        .q({halt_req_s, pwr_req_s, lock_init_s, inv_en_s, ninv_en_s, sinv_en_s, sninv_en_s})
    );

    dsa_sync #(.WIDTH(42)) u_sync_cfg (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .d({rom_base_cfg, rom_base_cfg_valid, self_offset_cfg, self_offset_cfg_valid}),
        .q({rom_base_s, rom_valid_s, self_ofs_s, self_valid_s})
    );

    // state
    logic debug_state;
    logic restarted;
    logic [3:0] entry_method;
    logic force_ack;
    logic [1:0] mode_select;
    logic rx_full;
    logic tx_full;
    logic [31:0] rx_word;
    logic [31:0] tx_word;
    logic no_pwr_down;
    logic lock_done;
    logic [1:0] lock_cnt;
    dsa_pkg::dsa_pwr_state_t pwr_state;
    dsa_pkg::dsa_pwr_state_t next_pwr_state;

    // avalon access decode
    wire bus_req = avs_read || avs_write;
    wire commit = bus_req && !avs_waitrequest;
    wire wr_commit = commit && avs_write;
    wire rd_commit = commit && avs_read;
    wire sel_ctrl = avs_address == dsa_pkg::OFS_CTRL;
    wire sel_rx = avs_address == dsa_pkg::OFS_CHAN_RX;
    wire sel_tx = avs_address == dsa_pkg::OFS_CHAN_TX;
    wire sel_pctl = avs_address == dsa_pkg::OFS_PWR_CTRL;
    wire sel_pst = avs_address == dsa_pkg::OFS_PWR_STAT;
    wire sel_auth = avs_address == dsa_pkg::OFS_AUTH_STAT;
    wire sel_rom = avs_address == dsa_pkg::OFS_ROM_BASE;
    wire sel_self = avs_address == dsa_pkg::OFS_SELF_OFS;
    wire sel_lock = avs_address == dsa_pkg::OFS_OS_LOCK;
    wire sel_rst = avs_address == dsa_pkg::OFS_RESTART;

    // authentication decode
    dsa_pkg::dsa_perm_t next_perm;
    assign next_perm.nonsecure_invasive = inv_en_s;
    assign next_perm.secure_invasive = inv_en_s && sinv_en_s;
    assign next_perm.nonsecure_noninvasive = inv_en_s || ninv_en_s;
    assign next_perm.secure_noninvasive = (inv_en_s || ninv_en_s) && (sinv_en_s || sninv_en_s);

    // mode field reads as none while invasive debug is off
    wire [1:0] mode_effective = inv_en_s ? mode_select : dsa_pkg::MODE_NONE;

    // halt and restart
    wire halt_event = halt_req_s && inv_en_s && !debug_state;
    wire [31:0] ctrl_merged = merge_bytes(WORD_CTRL_STORE(force_ack, mode_select), avs_writedata, avs_byteenable);
    wire restart_req = wr_commit && sel_rst && avs_byteenable[0] && avs_writedata[dsa_pkg::BIT_RESTART_REQ];
    wire next_debug_state = halt_event ? 1'b1 : (restart_req ? 1'b0 : debug_state);
    wire next_force_ack = (wr_commit && sel_ctrl) ? ctrl_merged[dsa_pkg::BIT_FORCE_ACK] : force_ack;
    wire next_ack = next_debug_state || next_force_ack;

    // holds only the writable control fields, other positions zero
    function automatic logic [31:0] WORD_CTRL_STORE(input logic fa, input logic [1:0] ms);
        logic [31:0] w;
        w = dsa_pkg::WORD_ZERO;
        w[dsa_pkg::BIT_FORCE_ACK] = fa;
        w[dsa_pkg::MODE_HI:dsa_pkg::MODE_LO] = ms;
        return w;
    endfunction : WORD_CTRL_STORE

    // communications channel: fills only when empty, so clear wins in the same cycle
    wire rx_fill = wr_commit && sel_rx && !rx_full;
    wire rx_drain = core_req.rx_read && rx_full;
    wire next_rx_full = rx_fill || (rx_full && !rx_drain);
    wire tx_fill = core_req.tx_write && !tx_full;
    wire tx_drain = rd_commit && sel_tx && tx_full;
    wire next_tx_full = tx_fill || (tx_full && !tx_drain);

    // power control
    wire [31:0] pctl_merged = merge_bytes({31'h0000_0000, no_pwr_down}, avs_writedata, avs_byteenable);
    wire next_no_pwr_down = (wr_commit && sel_pctl) ? pctl_merged[dsa_pkg::BIT_NO_PWR_DOWN] : no_pwr_down;

    always_comb begin
        next_pwr_state = pwr_state;
        unique case (pwr_state)
            dsa_pkg::PWR_ON: begin
                if (pwr_req_s) begin
                    next_pwr_state = dsa_pkg::PWR_WAIT_IDLE;
                end
            end
            dsa_pkg::PWR_WAIT_IDLE: begin
                if (!pwr_req_s) begin
                    next_pwr_state = dsa_pkg::PWR_ON;
                end else if (core_quiescent) begin
                    next_pwr_state = dsa_pkg::PWR_ACKED;
                end
            end
            dsa_pkg::PWR_ACKED: begin
                if (!pwr_req_s) begin
                    next_pwr_state = dsa_pkg::PWR_ON;
                end
            end
            default: begin
                next_pwr_state = dsa_pkg::PWR_ON;
            end
        endcase
    end

    // os lock: written by software, strap caught once after reset release
    wire lock_capture = !lock_done && (lock_cnt == dsa_pkg::LOCK_CAPTURE_CYCLES);
    wire lock_wr = wr_commit && sel_lock && avs_byteenable[0];
    wire next_os_lock = lock_capture ? lock_init_s : (lock_wr ? avs_writedata[dsa_pkg::BIT_OS_LOCK] : os_lock);

    // read data mux
    logic [31:0] ctrl_word;
    logic [31:0] rd_mux;
    always_comb begin
        ctrl_word = dsa_pkg::WORD_ZERO;
        ctrl_word[dsa_pkg::BIT_HALTED] = debug_state;
        ctrl_word[dsa_pkg::BIT_RESTARTED] = restarted;
        ctrl_word[dsa_pkg::ENTRY_HI:dsa_pkg::ENTRY_LO] = entry_method;
        ctrl_word[dsa_pkg::BIT_FORCE_ACK] = force_ack;
        ctrl_word[dsa_pkg::MODE_HI:dsa_pkg::MODE_LO] = mode_effective;
        ctrl_word[dsa_pkg::BIT_TX_FULL] = tx_full;
        ctrl_word[dsa_pkg::BIT_RX_FULL] = rx_full;
        rd_mux = dsa_pkg::WORD_ZERO;
        if (sel_ctrl) begin
            rd_mux = ctrl_word;
        end else if (sel_tx) begin
            rd_mux = tx_word;
        end else if (sel_pctl) begin
            rd_mux[dsa_pkg::BIT_NO_PWR_DOWN] = no_pwr_down;
        end else if (sel_pst) begin
            rd_mux[dsa_pkg::BIT_PWR_DOWN_REQ] = pwr_req_s;
        end else if (sel_auth) begin
            rd_mux[3:0] = debug_permission;
        end else if (sel_rom) begin
            rd_mux[dsa_pkg::CFG_HI:dsa_pkg::CFG_LO] = rom_base_s;
            rd_mux[dsa_pkg::BIT_CFG_VALID] = rom_valid_s;
        end else if (sel_self) begin
            rd_mux[dsa_pkg::CFG_HI:dsa_pkg::CFG_LO] = self_ofs_s;
            rd_mux[dsa_pkg::BIT_CFG_VALID] = self_valid_s;
        end else if (sel_lock) begin
            rd_mux[dsa_pkg::BIT_OS_LOCK] = os_lock;
        end
    end

    // bus slave: one wait cycle, then the access completes
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= dsa_pkg::WORD_ZERO;
        end else begin
            avs_waitrequest <= !(bus_req && avs_waitrequest);
            if (bus_req && avs_waitrequest) begin
                avs_readdata <= avs_read ? rd_mux : dsa_pkg::WORD_ZERO;
            end
        end
    end

    // debug state, handshake and control fields
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            debug_state <= 1'b0;
            restarted <= 1'b1;
            entry_method <= dsa_pkg::ENTRY_RESET;
            force_ack <= 1'b0;
            mode_select <= dsa_pkg::MODE_NONE;
            debug_state_acknowledge <= 1'b0;
            core_halted <= 1'b0;
        end else begin
            debug_state <= next_debug_state;
            core_halted <= next_debug_state;
            debug_state_acknowledge <= next_ack;
            force_ack <= next_force_ack;
            if (halt_event) begin
                entry_method <= dsa_pkg::ENTRY_EXT_HALT;
                restarted <= 1'b0;
            end else if (restart_req && debug_state) begin
                restarted <= 1'b1;
            end
            if (wr_commit && sel_ctrl) begin
                mode_select <= ctrl_merged[dsa_pkg::MODE_HI:dsa_pkg::MODE_LO];
            end
        end
    end

    // communications channel
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            rx_full <= 1'b0;
            tx_full <= 1'b0;
            rx_word <= dsa_pkg::WORD_ZERO;
            tx_word <= dsa_pkg::WORD_ZERO;
            channel_transmit_ready <= 1'b1;
        end else begin
            rx_full <= next_rx_full;
            tx_full <= next_tx_full;
            channel_transmit_ready <= !next_tx_full;
            if (rx_fill) begin
                rx_word <= merge_bytes(rx_word, avs_writedata, avs_byteenable);
            end
            if (tx_fill) begin
                tx_word <= core_req.tx_data;
            end
        end
    end
    assign channel_receive_pending = rx_full;
    assign core_rx_data = rx_word;

    // power, lock and permissions
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            no_pwr_down <= 1'b0;
            no_power_down_out <= 1'b0;
            pwr_state <= dsa_pkg::PWR_ON;
            power_down_ack_out <= 1'b0;
            os_lock <= 1'b0;
            lock_done <= 1'b0;
            lock_cnt <= 2'h0;
            debug_permission <= '0;
        end else begin
            no_pwr_down <= next_no_pwr_down;
            no_power_down_out <= next_no_pwr_down;
            pwr_state <= next_pwr_state;
            power_down_ack_out <= next_pwr_state == dsa_pkg::PWR_ACKED;
            os_lock <= next_os_lock;
            if (lock_capture) begin
                lock_done <= 1'b1;
            end else if (!lock_done) begin
                lock_cnt <= lock_cnt + 2'h1;
            end
            debug_permission <= next_perm;
        end
    end
endmodule : dsa_top
`default_nettype wire

// ### verif/dsa_props.sv
// port assertions of the debug sideband block
`timescale 1ns/1ps
`default_nettype none
module dsa_props (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic ext_halt_request,
    input wire logic debug_state_acknowledge,
    input wire logic channel_receive_pending,
    input wire logic channel_transmit_ready,
    input wire dsa_pkg::dsa_core_req_t core_req,
    input wire logic core_halted,
    input wire logic core_quiescent,
    input wire logic no_power_down_out,
    input wire logic power_down_request_in,
    input wire logic power_down_ack_out,
    input wire logic [19:0] rom_base_cfg,
    input wire logic rom_base_cfg_valid,
    input wire logic invasive_enable,
    input wire logic noninvasive_enable,
    input wire logic secure_invasive_enable,
    input wire logic secure_noninvasive_enable,
    input wire dsa_pkg::dsa_perm_t debug_permission
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    logic [2:0] up_cnt;
    wire logic done = !avs_waitrequest && (avs_read || avs_write);
    wire logic inv = invasive_enable;
    wire logic any = invasive_enable | noninvasive_enable;
    wire logic sec = secure_invasive_enable | secure_noninvasive_enable;
    wire logic [3:0] perm_exp = {secure_invasive_enable & inv, inv, any & sec, any};
    // cycles since reset release, saturating once the pin pipeline is full
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            up_cnt <= 3'h0;
        end else if (up_cnt != 3'h4) begin
            up_cnt <= up_cnt + 3'h1;
        end
    end
    sequence s_halt_held;
        (ext_halt_request && invasive_enable && !core_halted) [*3];
    endsequence
    sequence s_pd_idle;
        (!power_down_request_in) [*5];
    endsequence
    a_perm_decode: assert property (up_cnt == 3'h4 |-> debug_permission == $past(perm_exp, 3))
        else $error("permission decode wrong");
    a_halt_entry: assert property (s_halt_held |=> core_halted)
        else $error("halt request not taken");
    a_halt_blocked: assert property ((!invasive_enable) [*4] |-> !$rose(core_halted))
        else $error("halt taken while invasive debug off");
    a_ack_in_debug: assert property (core_halted |-> debug_state_acknowledge)
        else $error("acknowledge low in debug state");
    a_rx_clear: assert property (core_req.rx_read && channel_receive_pending |=> !channel_receive_pending)
        else $error("receive pending not cleared");
    a_rx_fill: assert property (done && avs_write && avs_address == dsa_pkg::OFS_CHAN_RX |=>
        channel_receive_pending)
        else $error("receive pending not set");
    a_tx_fill: assert property (core_req.tx_write && channel_transmit_ready |=> !channel_transmit_ready)
        else $error("transmit ready not cleared");
    a_tx_drain: assert property (done && avs_read && avs_address == dsa_pkg::OFS_CHAN_TX |=>
        channel_transmit_ready)
        else $error("transmit ready not restored");
    a_nopd_follow: assert property (done && avs_write && avs_address == dsa_pkg::OFS_PWR_CTRL |=>
        no_power_down_out == $past(avs_writedata[0]))
        else $error("no power down output wrong");
    a_pd_ack_rise: assert property ($rose(power_down_ack_out) |->
        $past(power_down_request_in, 3) && $past(core_quiescent))
        else $error("power down ack too early");
    a_pd_ack_fall: assert property (s_pd_idle |-> !power_down_ack_out)
        else $error("power down ack without request");
    a_rom_read: assert property (done && avs_read && avs_address == dsa_pkg::OFS_ROM_BASE |->
        avs_readdata == {rom_base_cfg, 11'h000, rom_base_cfg_valid})
        else $error("rom base readback wrong");
    a_wait_single: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("waitrequest not single cycle");
endmodule : dsa_props
bind dsa_top dsa_props u_props (.*);
`default_nettype wire

// ### verif/dsa_partner.sv
// far side model: halt requester, power controller and core quiescence
`timescale 1ns/1ps
`default_nettype none
module dsa_partner (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic halt_go,
    input wire logic pd_go,
    input wire logic [3:0] quiet_wait,
    input wire logic debug_state_acknowledge,
    output logic ext_halt_request,
    output logic power_down_request_in,
    output logic core_quiescent
);
    logic [3:0] quiet_cnt;
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            ext_halt_request <= 1'h0;
            power_down_request_in <= 1'h0;
            quiet_cnt <= 4'h0;
        end else begin
            if (halt_go) begin
                ext_halt_request <= 1'h1;
            end else if (debug_state_acknowledge) begin
                ext_halt_request <= 1'h0;
            end
            power_down_request_in <= pd_go;
            if (!power_down_request_in) begin
                quiet_cnt <= 4'h0;
            end else if (quiet_cnt != quiet_wait) begin
                quiet_cnt <= quiet_cnt + 4'h1;
            end
        end
    end
    assign core_quiescent = power_down_request_in && quiet_cnt == quiet_wait;
endmodule : dsa_partner
`default_nettype wire

// ### verif/dsa_top_test.sv
// self-checking bench for the debug sideband block
`timescale 1ns/1ps
`default_nettype none
module dsa_top_test;
    logic sys_clk, reset_n, avs_read, avs_write, avs_waitrequest, halt_go, pd_go;
    logic [7:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, core_rx_data, rd;
    logic [3:0] avs_byteenable, quiet_wait, auth, ep;
    logic ext_halt_request, debug_state_acknowledge, channel_receive_pending, channel_transmit_ready;
    logic core_halted, core_quiescent, no_power_down_out, power_down_request_in, power_down_ack_out;
    logic os_lock_init_in, os_lock, rom_base_cfg_valid, self_offset_cfg_valid;
    logic secure_invasive_enable, invasive_enable, secure_noninvasive_enable, noninvasive_enable;
    logic [19:0] rom_base_cfg, self_offset_cfg;
    dsa_pkg::dsa_core_req_t core_req;
    dsa_pkg::dsa_perm_t debug_permission;
    int err_count, num_checks, cyc, n, i;
    dsa_top dut (.*);
    dsa_partner model (.*);
    initial begin
        sys_clk = 1'h0;
        forever #5 sys_clk = ~sys_clk;
    end
    task give_verdict;
        if (err_count == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            give_verdict();
        end
    end
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task chk_bit(input string nm, input logic e, input logic g);
        chk(nm, {31'h0, e}, {31'h0, g});
    endtask : chk_bit
    task tick(input int c);
        repeat (c) @(posedge sys_clk);
    endtask : tick
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= 4'hF;
        avs_write <= wr;
        avs_read <= !wr;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'h0 && n < 40);
        rd = avs_readdata;
        avs_write <= 1'h0;
        avs_read <= 1'h0;
        if (n >= 40) chk_bit("waitrequest", 1'h0, 1'h1);
    endtask : bus
    task rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        bus(1'h0, a, 32'h0);
        chk(nm, e, rd);
    endtask : rdchk
    task set_auth(input logic [3:0] v);
        {secure_invasive_enable, invasive_enable, secure_noninvasive_enable, noninvasive_enable} <= v;
        tick(5);
    endtask : set_auth
    task reset_pulse(input logic strap);
        reset_n <= 1'h0;
        os_lock_init_in <= strap;
        tick(12);
        reset_n <= 1'h1;
        tick(6);
    endtask : reset_pulse
    initial begin
        {err_count, num_checks, cyc} = '0;
        {reset_n, avs_read, avs_write, halt_go, pd_go, os_lock_init_in} = '0;
        {avs_address, avs_writedata, avs_byteenable, quiet_wait, core_req} = '0;
        {secure_invasive_enable, invasive_enable, secure_noninvasive_enable, noninvasive_enable} = 4'h0;
        {rom_base_cfg, rom_base_cfg_valid, self_offset_cfg, self_offset_cfg_valid} = {20'hABCDE, 1'h1, 20'h12345, 1'h1};
        reset_pulse(1'h0);
        chk_bit("os_lock", 1'h0, os_lock);
        chk_bit("tx_ready", 1'h1, channel_transmit_ready);
        rdchk("ctrl", dsa_pkg::OFS_CTRL, 32'h0000_0002);
        rdchk("unmapped", 8'h30, 32'h0);
        rdchk("rom_base", dsa_pkg::OFS_ROM_BASE, 32'hABCD_E001);
        rdchk("self_ofs", dsa_pkg::OFS_SELF_OFS, 32'h1234_5001);
        for (i = 0; i < 16; i++) begin
            auth = i[3:0];
            set_auth(auth);
            ep = {auth[3] & auth[2], auth[2], (auth[2] | auth[0]) & (auth[3] | auth[1]), auth[2] | auth[0]};
            chk("permission", {28'h0, ep}, {28'h0, debug_permission});
            rdchk("auth_stat", dsa_pkg::OFS_AUTH_STAT, {28'h0, ep});
        end
        set_auth(4'h0);
        bus(1'h1, dsa_pkg::OFS_CTRL, 32'h0000_C000);
        rdchk("mode_off", dsa_pkg::OFS_CTRL, 32'h0000_0002);
        halt_go <= 1'h1;
        tick(1);
        halt_go <= 1'h0;
        tick(10);
        chk_bit("halt_ignored", 1'h0, core_halted);
        set_auth(4'hF);
        for (n = 0; n < 20 && debug_state_acknowledge !== 1'h1; n++) tick(1);
        chk_bit("ack", 1'h1, debug_state_acknowledge);
        rdchk("ctrl_halted", dsa_pkg::OFS_CTRL, 32'h0000_C011);
        chk_bit("halt_pin_dropped", 1'h0, ext_halt_request);
        bus(1'h1, dsa_pkg::OFS_RESTART, 32'h0000_0002);
        tick(2);
        chk_bit("ack_restart", 1'h0, debug_state_acknowledge);
        bus(1'h1, dsa_pkg::OFS_CTRL, 32'h0000_C400);
        tick(2);
        chk_bit("force_ack", 1'h1, debug_state_acknowledge);
        bus(1'h1, dsa_pkg::OFS_CTRL, 32'h0000_C000);
        tick(2);
        chk_bit("force_ack_off", 1'h0, debug_state_acknowledge);
        bus(1'h1, dsa_pkg::OFS_CHAN_RX, 32'hDEAD_BEEF);
        bus(1'h1, dsa_pkg::OFS_CHAN_RX, 32'h1111_1111);
        tick(1);
        chk_bit("rx_pending", 1'h1, channel_receive_pending);
        chk("rx_word", 32'hDEAD_BEEF, core_rx_data);
        core_req <= '{1'h1, 1'h0, 32'h0};
        tick(1);
        core_req <= '{1'h0, 1'h1, 32'hCAFE_F00D};
        tick(1);
        core_req <= '0;
        tick(1);
        chk_bit("rx_drained", 1'h0, channel_receive_pending);
        chk_bit("tx_busy", 1'h0, channel_transmit_ready);
        bus(1'h0, dsa_pkg::OFS_CTRL, 32'h0);
        chk_bit("tx_full", 1'h1, rd[29]);
        rdchk("tx_word", dsa_pkg::OFS_CHAN_TX, 32'hCAFE_F00D);
        tick(1);
        chk_bit("tx_ready_again", 1'h1, channel_transmit_ready);
        for (i = 0; i < 2; i++) begin
            bus(1'h1, dsa_pkg::OFS_PWR_CTRL, 32'h1 - i);
            tick(1);
            chk_bit("no_power_down", !i[0], no_power_down_out);
            quiet_wait <= i[0] ? 4'h6 : 4'h0;
            pd_go <= 1'h1;
            tick(4);
            rdchk("pwr_stat_req", dsa_pkg::OFS_PWR_STAT, 32'h1);
            for (n = 0; n < 30 && power_down_ack_out !== 1'h1; n++) tick(1);
            chk_bit("pd_ack", 1'h1, power_down_ack_out);
            pd_go <= 1'h0;
            for (n = 0; n < 10 && power_down_ack_out !== 1'h0; n++) tick(1);
            chk_bit("pd_ack_low", 1'h0, power_down_ack_out);
            rdchk("pwr_stat_idle", dsa_pkg::OFS_PWR_STAT, 32'h0);
        end
        {rom_base_cfg, rom_base_cfg_valid, self_offset_cfg, self_offset_cfg_valid} <= '0;
        reset_pulse(1'h1);
        chk_bit("os_lock_strap", 1'h1, os_lock);
        rdchk("rom_tied", dsa_pkg::OFS_ROM_BASE, 32'h0);
        rdchk("self_tied", dsa_pkg::OFS_SELF_OFS, 32'h0);
        bus(1'h1, dsa_pkg::OFS_OS_LOCK, 32'h0);
        rdchk("os_lock_reg", dsa_pkg::OFS_OS_LOCK, 32'h0);
        chk_bit("os_lock_cleared", 1'h0, os_lock);
        give_verdict();
    end
endmodule : dsa_top_test
`default_nettype wire
